// [lcg_char_gen.sv]
// lcg_char_gen: pattern ROM plus 64-byte user pattern RAM, code decode,
// cursor-row merge and host write path with stepping address counter.
// assumes: host bus handshake, display RAM and cursor timing live outside.
//
// Functional notes
// - ROM gives dot rows for 160 small glyphs and 32 tall glyphs.
// - ROM code stored in display RAM shows matching ROM glyph there.
// - user pattern RAM holds 64 bytes: eight small or four tall glyphs.
// - small font: address bits 0-2 select the glyph row.
// - host data lines 0-7 land on pattern bits 0-7 in order.
// - a high pattern bit lights its dot, low leaves it dark.
// - each pattern RAM write steps the address counter by one, up or down.
// - small font row 7 is cursor row, ORed with the cursor.
// - only bits 0-4 reach the display; bits 5-7 stored and readable.
// - upper four code bits zero selects user RAM over ROM.
// - small font ignores code bit 3 for user glyphs.
// - small font code bits 0-2 drive RAM address bits 3-5.
// - tall font: address bits 0-3 select the glyph row.
// - tall font row A is cursor row, ORed with the cursor.
// - tall font rows 0-A display; rows B-F are memory only.
// - tall font ignores code bits 0 and 3 for user glyphs.
// - tall font code bits 1-2 drive RAM address bits 4-5.
// - reset selects small font and incrementing address counter.
`default_nettype none

module lcg_char_gen
  import lcg_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // mode control from the instruction logic
  input  wire logic                  fontSet,
  input  wire logic                  fontTallIn,
  input  wire logic                  dirSet,
  input  wire logic                  dirIncIn,
  // address counter load
  input  wire logic                  addrLoad,
  input  wire logic [RAM_ADDR_W-1:0] addrLoadVal,
  // host access to pattern RAM
  input  wire logic                  hostWrite,
  input  wire logic                  hostRead,
  input  wire logic [RAM_DATA_W-1:0] hostDataLines,
  output var  logic [RAM_DATA_W-1:0] hostReadData_reg,
  // status back to the instruction logic
  output var  logic [RAM_ADDR_W-1:0] addrCount_reg,
  output var  logic                  fontTall_reg,
  output var  logic                  dirInc_reg,
  // display fetch
  input  wire logic                  fetchValid,
  input  wire logic [CODE_W-1:0]     fetchCode,
  input  wire logic [ROW_W-1:0]      fetchRow,
  input  wire logic                  cursorOn,
  // dot row out
  output var  logic [DOT_W-1:0]      dots_reg,
  output var  logic                  dotsValid_reg
);
  // ----------------------------------------------------------------
  // mode state
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fontTall_reg <= (FONT_RESET == FONT_TALL);
    end else if (fontSet) begin
      fontTall_reg <= fontTallIn;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dirInc_reg <= DIR_RESET;
    end else if (dirSet) begin
      dirInc_reg <= dirIncIn;
    end
  end

  // ----------------------------------------------------------------
  // address counter
  // ----------------------------------------------------------------
  logic                  hostAccess;
  logic [RAM_ADDR_W-1:0] addrStepUp;
  logic [RAM_ADDR_W-1:0] addrStepDown;
  logic [RAM_ADDR_W-1:0] addrCount_next;

  // a load owns its cycle: no store, no step
  assign hostAccess   = (hostWrite || hostRead) && !addrLoad;
  // six-bit sums wrap modulo the RAM depth
  assign addrStepUp   = addrCount_reg + ADDR_STEP;
  assign addrStepDown = addrCount_reg - ADDR_STEP;

  always_comb begin
    addrCount_next = addrCount_reg;
    if (addrLoad) begin
      addrCount_next = addrLoadVal;
    end else if (hostAccess) begin
      if (dirInc_reg) begin
        addrCount_next = addrStepUp;
      end else begin
        addrCount_next = addrStepDown;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      addrCount_reg <= '0;
    end else begin
      addrCount_reg <= addrCount_next;
    end
  end

  // ----------------------------------------------------------------
  // pattern RAM
  // ----------------------------------------------------------------
  // full 8-bit bytes, all 64 rows, stay readable as memory
  logic [RAM_DATA_W-1:0] patternRam [RAM_DEPTH];
  logic                  ramWrite;
  logic                  ramRead;
  logic [RAM_DATA_W-1:0] ramReadByte;

  assign ramWrite    = hostWrite && !addrLoad;
  assign ramRead     = hostRead && !addrLoad;
  assign ramReadByte = patternRam[addrCount_reg];

  always_ff @(posedge clk) begin
    if (ramWrite) begin
      patternRam[addrCount_reg] <= hostDataLines;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      hostReadData_reg <= '0;
    end else if (ramRead) begin
      hostReadData_reg <= ramReadByte;
    end
  end

  // ----------------------------------------------------------------
  // display fetch decode
  // ----------------------------------------------------------------
  logic                   userSel;
  logic [SMALL_ROW_W-1:0] smallRow;
  logic [RAM_ADDR_W-1:0]  userAddrSmall;
  logic [RAM_ADDR_W-1:0]  userAddrTall;
  logic                   cursorRowSmall;
  logic                   cursorRowTall;
  logic                   rowShownTall;
  logic [RAM_ADDR_W-1:0]  userAddr;
  logic                   rowShown;
  logic                   cursorRow;
  logic                   cursorHit;
  logic [ROM_ADDR_W-1:0]  romAddr;

  assign userSel  = (fetchCode[CODE_W-1:USER_HIGH_LSB] == USER_CODE_HIGH);
  assign smallRow = fetchRow[SMALL_ROW_W-1:0];
  assign romAddr  = {fetchCode, fetchRow};

  // ----------------------------------------------------------------
  // small font decode
  // ----------------------------------------------------------------
  // code bit 3 dropped bits 2:0 pick the glyph
  assign userAddrSmall  = {fetchCode[SMALL_SEL_W-1:0], smallRow};
  assign cursorRowSmall = (smallRow == CURSOR_ROW_SMALL[SMALL_ROW_W-1:0]);

  // ----------------------------------------------------------------
  // tall font decode
  // ----------------------------------------------------------------
  // code bits 0 and 3 dropped bits 2:1 pick the glyph
  assign userAddrTall  = {fetchCode[TALL_SEL_MSB:TALL_SEL_LSB], fetchRow};
  assign cursorRowTall = (fetchRow == CURSOR_ROW_TALL);
  assign rowShownTall  = (fetchRow <= LAST_ROW_TALL);

  // ----------------------------------------------------------------
  // font select
  // ----------------------------------------------------------------
  always_comb begin
    userAddr  = userAddrSmall;
    rowShown  = 1'h1;
    cursorRow = cursorRowSmall;
    if (fontTall_reg) begin
      userAddr  = userAddrTall;
      rowShown  = rowShownTall;
      cursorRow = cursorRowTall;
    end
  end

  assign cursorHit = cursorRow && cursorOn;

  // ----------------------------------------------------------------
  // pattern ROM
  // ----------------------------------------------------------------
  logic [DOT_W-1:0] romDots;

  lcg_pattern_rom lcg_pattern_rom_inst (
    .clk     (clk),
    .romAddr (romAddr),
    .romDots (romDots)
  );

  // ----------------------------------------------------------------
  // user RAM read stage
  // ----------------------------------------------------------------
  logic [DOT_W-1:0] ramDots_reg;
  logic             userSel_reg;
  logic             rowShown_reg;
  logic             cursorHit_reg;
  logic             fetch_reg;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ramDots_reg <= '0;
    end else begin
      ramDots_reg <= patternRam[userAddr][DOT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // fetch status stage
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      userSel_reg <= 1'h0;
    end else begin
      userSel_reg <= userSel;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rowShown_reg <= 1'h0;
    end else begin
      rowShown_reg <= rowShown;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cursorHit_reg <= 1'h0;
    end else begin
      cursorHit_reg <= cursorHit;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fetch_reg <= 1'h0;
    end else begin
      fetch_reg <= fetchValid;
    end
  end

  // ----------------------------------------------------------------
  // output merge
  // ----------------------------------------------------------------
  logic [DOT_W-1:0] shownDots;
  logic [DOT_W-1:0] cursorDots;
  logic [DOT_W-1:0] glyphDots;
  logic [DOT_W-1:0] dots_next;

  assign shownDots  = userSel_reg ? ramDots_reg : romDots;
  assign cursorDots = {DOT_W{cursorHit_reg}};

  always_comb begin
    glyphDots = shownDots;
    if (!rowShown_reg) begin
      glyphDots = '0;
    end
  end

  // high bit lights the dot
  assign dots_next = glyphDots | cursorDots;

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dots_reg <= '0;
    end else begin
      dots_reg <= dots_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dotsValid_reg <= 1'h0;
    end else begin
      dotsValid_reg <= fetch_reg;
    end
  end
endmodule : lcg_char_gen

`default_nettype wire

// [lcg_char_gen_asserts.sv]
// lcg_char_gen_asserts: port-level timing and decode checks.
// assumes: bound to lcg_char_gen, one clock, synchronous active-low reset.
`default_nettype none

module lcg_char_gen_asserts
  import lcg_pkg::*;
(
  input wire logic                  clk, nrst, fontSet, fontTallIn, dirSet, dirIncIn,
  input wire logic                  addrLoad, hostWrite, hostRead, fetchValid, cursorOn,
  input wire logic [RAM_ADDR_W-1:0] addrLoadVal, addrCount_reg,
  input wire logic [RAM_DATA_W-1:0] hostDataLines, hostReadData_reg,
  input wire logic                  fontTall_reg, dirInc_reg, dotsValid_reg,
  input wire logic [CODE_W-1:0]     fetchCode,
  input wire logic [ROW_W-1:0]      fetchRow,
  input wire logic [DOT_W-1:0]      dots_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire acc = (hostWrite | hostRead) & ~addrLoad;

  a_fetch_lat: assert property (fetchValid |-> ##2 dotsValid_reg)
    else $error("fetch answer missing");
  a_step_up: assert property (
    acc && dirInc_reg |=> addrCount_reg == $past(addrCount_reg) + 6'h01)
    else $error("counter not incremented");
  a_step_down: assert property (
    acc && !dirInc_reg |=> addrCount_reg == $past(addrCount_reg) - 6'h01)
    else $error("counter not decremented");
  a_load_wins: assert property (addrLoad |=> addrCount_reg == $past(addrLoadVal))
    else $error("address load lost");
  a_font_load: assert property (fontSet |=> fontTall_reg == $past(fontTallIn))
    else $error("font not loaded");
  a_font_hold: assert property (!fontSet |=> $stable(fontTall_reg))
    else $error("font changed unasked");
  a_read_hold: assert property (!(hostRead && !addrLoad) |=> $stable(hostReadData_reg))
    else $error("read data changed unasked");
  a_tall_blank: assert property (
    fetchValid && fontTall_reg && fetchRow > 4'hA |-> ##2 dots_reg == 5'h00)
    else $error("hidden tall row shown");
  a_cursor_small: assert property (
    fetchValid && !fontTall_reg && fetchRow[2:0] == 3'h7 && cursorOn
    |-> ##2 dots_reg == 5'h1F)
    else $error("small cursor row not merged");
  a_cursor_tall: assert property (
    fetchValid && fontTall_reg && fetchRow == 4'hA && cursorOn
    |-> ##2 dots_reg == 5'h1F)
    else $error("tall cursor row not merged");
endmodule : lcg_char_gen_asserts

bind lcg_char_gen lcg_char_gen_asserts lcg_char_gen_asserts_inst (.*);

`default_nettype wire

// [lcg_char_gen_tb_top.sv]
// lcg_char_gen_tb_top: directed checks of pattern RAM, decode and cursor merge.
// assumes: glyph table left at its all-zero default.
`default_nettype none

module lcg_char_gen_tb_top
  import lcg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 0, nrst = 0, fontSet = 0, fontTallIn = 0, fetchValid = 0, cursorOn = 0;
  logic       hostWrite, hostRead, addrLoad, dirSet, dirIncIn, fontTall_reg, dirInc_reg;
  logic       dotsValid_reg;
  logic [5:0] addrLoadVal, addrCount_reg;
  logic [7:0] hostDataLines, hostReadData_reg, fetchCode = 8'h00;
  logic [3:0] fetchRow = 4'h0;
  logic [4:0] dots_reg;
  int         error_cnt = 0, tests_run = 0;

  always #2.5 clk = ~clk;
  lcg_char_gen lcg_char_gen_inst (.*);
  lcg_host_model lcg_host_model_inst (.*);

  function automatic logic [7:0] pat(input int a);
    return 8'(a * 8'h1D + 8'hA6);
  endfunction : pat

  task automatic chk(input logic [7:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic fetch(input logic [7:0] code, input logic [3:0] row, input logic cur,
                       input logic [7:0] exp);
    @(negedge clk);
    {fetchValid, fetchCode, fetchRow, cursorOn} = {1'b1, code, row, cur};
    @(negedge clk);
    fetchValid = 0;
    @(negedge clk);
    chk({7'h00, dotsValid_reg}, 8'h01);
    chk({3'h0, dots_reg}, exp & 8'h1F);
  endtask : fetch

  task automatic t_small;
    lcg_host_model_inst.pulse(0, 0, 1, 0, 8'h08);
    for (int r = 0; r < 8; r++) begin
      lcg_host_model_inst.pulse(1, 0, 0, 0, r == 7 ? pat(15) & 8'hE0 : pat(r + 8));
    end
    chk({2'h0, addrCount_reg}, 8'h10);
    lcg_host_model_inst.pulse(0, 0, 1, 0, 8'h0F);
    lcg_host_model_inst.pulse(0, 1, 0, 0, 8'h00);
    chk(hostReadData_reg, pat(15) & 8'hE0);
    for (int r = 0; r < 7; r++) begin
      fetch(8'h01, 4'(r), 1, pat(r + 8));
      fetch(8'h09, 4'(r), 0, pat(r + 8));
    end
    fetch(8'h01, 4'h7, 1, 8'h1F);
    fetch(8'h09, 4'h7, 0, 8'h00);
    fetch(8'h11, 4'h0, 0, 8'h00);
  endtask : t_small

  task automatic t_dec;
    lcg_host_model_inst.pulse(0, 0, 0, 1, 8'h00);
    lcg_host_model_inst.pulse(0, 0, 1, 0, 8'h00);
    lcg_host_model_inst.pulse(1, 0, 0, 0, 8'h55);
    chk({2'h0, addrCount_reg}, 8'h3F);
    lcg_host_model_inst.pulse(1, 0, 1, 0, 8'h00);
    chk({2'h0, addrCount_reg}, 8'h00);
    lcg_host_model_inst.pulse(0, 1, 0, 0, 8'h00);
    chk(hostReadData_reg, 8'h55);
    chk({2'h0, addrCount_reg}, 8'h3F);
    lcg_host_model_inst.pulse(0, 0, 0, 1, 8'h01);
  endtask : t_dec

  task automatic t_tall;
    @(negedge clk);
    {fontSet, fontTallIn} = 2'h3;
    @(negedge clk);
    fontSet = 0;
    chk({7'h00, fontTall_reg}, 8'h01);
    lcg_host_model_inst.pulse(0, 0, 1, 0, 8'h20);
    for (int r = 0; r < 16; r++) begin
      lcg_host_model_inst.pulse(1, 0, 0, 0, r == 10 ? 8'h00 : pat(r + 32));
    end
    for (int i = 0; i < 4; i++) begin
      fetch(8'(4 + (i & 1) + 8 * (i >> 1)), 4'h3, 0, pat(35));
    end
    fetch(8'h04, 4'h0, 0, pat(32));
    fetch(8'h04, 4'hA, 1, 8'h1F);
    fetch(8'h05, 4'hB, 1, 8'h00);
    lcg_host_model_inst.pulse(0, 0, 1, 0, 8'h2B);
    lcg_host_model_inst.pulse(0, 1, 0, 0, 8'h00);
    chk(hostReadData_reg, pat(43));
  endtask : t_tall

  task automatic summarize;
    if (error_cnt == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  initial begin
    repeat (3) @(negedge clk);
    nrst = 1;
    chk({fontTall_reg, dirInc_reg, addrCount_reg}, 8'h40);
    t_small();
    t_dec();
    t_tall();
    summarize();
  end

  // about 27 times the expected run
  initial begin
    #20000;
    error_cnt++;
    summarize();
  end
endmodule : lcg_char_gen_tb_top

`default_nettype wire

// [lcg_host_model.sv]
// lcg_host_model: host side issuing address loads, writes and reads.
// assumes: every request is a one-cycle pulse launched at the falling edge.
`default_nettype none

module lcg_host_model
  import lcg_pkg::*;
(
  input  wire logic                  clk,
  output var  logic                  hostWrite, hostRead, addrLoad, dirSet, dirIncIn,
  output var  logic [RAM_ADDR_W-1:0] addrLoadVal,
  output var  logic [RAM_DATA_W-1:0] hostDataLines
);
  timeunit 1ns;
  timeprecision 1ps;

  initial {hostWrite, hostRead, addrLoad, dirSet, dirIncIn, addrLoadVal, hostDataLines} = '0;

  task automatic pulse(input logic w, r, l, d, input logic [7:0] v);
    @(negedge clk);
    {hostWrite, hostRead, addrLoad, dirSet} = {w, r, l, d};
    hostDataLines = v;
    addrLoadVal = v[5:0];
    dirIncIn = v[0];
    @(negedge clk);
    {hostWrite, hostRead, addrLoad, dirSet} = 4'h0;
    // released lines must not keep showing the last byte
    hostDataLines = ~hostDataLines;
  endtask : pulse
endmodule : lcg_host_model

`default_nettype wire

// [lcg_pattern_rom.sv]
// lcg_pattern_rom: fixed glyph store, one registered row per clock.
// assumes: contents supplied as a constant table by the integrator.
`default_nettype none

module lcg_pattern_rom
  import lcg_pkg::*;
(
  // clock
  input  wire logic                  clk,
  // lookup
  input  wire logic [ROM_ADDR_W-1:0] romAddr,
  output var  logic [DOT_W-1:0]      romDots
);
  // ----------------------------------------------------------------
  // table
  // ----------------------------------------------------------------
  // glyph shapes come from a separately supplied table
  parameter logic [DOT_W-1:0] GLYPH_TABLE [ROM_DEPTH] = '{default: '0};

  always_ff @(posedge clk) begin
    romDots <= GLYPH_TABLE[romAddr];
  end
endmodule : lcg_pattern_rom

`default_nettype wire

// [lcg_pkg.sv]
// lcg_pkg: constants for the character generator block.
// assumes: one 200 MHz clock, synchronous active-low reset.
`default_nettype none

package lcg_pkg;
  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int CODE_W       = 8;
  localparam int RAM_ADDR_W   = 6;
  localparam int RAM_DATA_W   = 8;
  localparam int RAM_DEPTH    = 64;
  localparam int DOT_W        = 5;
  localparam int ROW_W        = 4;
  localparam int ROM_ADDR_W   = CODE_W + ROW_W;
  localparam int ROM_DEPTH    = 4096;
  localparam int GLYPHS_SMALL = 160;
  localparam int GLYPHS_TALL  = 32;

  // ----------------------------------------------------------------
  // code and row field positions
  // ----------------------------------------------------------------
  localparam int USER_HIGH_LSB = 4;
  localparam int SMALL_ROW_W   = 3;
  localparam int SMALL_SEL_W   = 3;
  localparam int TALL_SEL_MSB  = 2;
  localparam int TALL_SEL_LSB  = 1;

  // ----------------------------------------------------------------
  // rows and codes
  // ----------------------------------------------------------------
  localparam logic [ROW_W-1:0]      CURSOR_ROW_SMALL = 4'h7;
  localparam logic [ROW_W-1:0]      CURSOR_ROW_TALL  = 4'hA;
  localparam logic [ROW_W-1:0]      LAST_ROW_TALL    = 4'hA;
  localparam logic [3:0]            USER_CODE_HIGH   = 4'h0;
  localparam logic [RAM_ADDR_W-1:0] ADDR_STEP        = 6'h01;

  // font selection and counter direction
  typedef enum logic {FONT_SMALL, FONT_TALL} lcg_font_t;
  localparam lcg_font_t FONT_RESET = FONT_SMALL;
  localparam logic      DIR_INC    = 1'b1;
  localparam logic      DIR_RESET  = DIR_INC;
endpackage : lcg_pkg

`default_nettype wire
